//--- verilog/stc_pkg.sv
// Constants, register map and types for the 16-bit timer/counter.
// Assumes a single 40 MHz clock and a byte-wide register port.
package stc_pkg;

  // ------------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 8;
  localparam int          COUNT_W     = 16;
  localparam int          CLK_HZ      = 40_000_000;
  localparam int          INSTR_DIV   = 4;
  localparam logic [1:0]  INSTR_LAST  = 2'(INSTR_DIV - 1);

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [3:0]  ADDR_CNT_LO = 4'h0;
  localparam logic [3:0]  ADDR_CNT_HI = 4'h1;
  localparam logic [3:0]  ADDR_CTRL   = 4'h2;
  localparam logic [3:0]  ADDR_GATE   = 4'h3;

  // Control register fields
  localparam int          CTRL_ON_BIT    = 0;
  localparam int          CTRL_OSCEN_BIT = 3;
  localparam int          CTRL_PS_LSB    = 4;
  localparam int          CTRL_SRC_LSB   = 6;

  // Gate control register fields
  localparam int          GATE_LVL_BIT   = 3;
  localparam int          GATE_POL_BIT   = 6;
  localparam int          GATE_EN_BIT    = 7;

  // Reset values
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  GATE_RST    = 8'h00;
  localparam logic [15:0] COUNT_RST   = 16'h0000;

  // Count source encodings
  localparam logic [1:0]  SRC_INSTR   = 2'h0;
  localparam logic [1:0]  SRC_SYS     = 2'h1;
  localparam logic [1:0]  SRC_EXT     = 2'h2;
  localparam logic [1:0]  SRC_CAP     = 2'h3;

  // ------------------------------------------------------------------
  // Types and decoders
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARM_WAIT_FALL = 2'b01,
    ARM_READY     = 2'b10
  } stc_arm_e;

  function automatic logic stc_is_count_addr(input logic [3:0] a);
    stc_is_count_addr = (a == ADDR_CNT_LO) || (a == ADDR_CNT_HI);
  endfunction : stc_is_count_addr

  function automatic logic stc_is_ext_src(input logic [1:0] s);
    stc_is_ext_src = (s == SRC_EXT) || (s == SRC_CAP);
  endfunction : stc_is_ext_src

endpackage : stc_pkg

//--- verilog/stc_edge_detect.sv
// Edge detector for the selected external count source.
// Assumes the level input is already synchronous to mclk.
module stc_edge_detect
  import stc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic level,
  output logic      risePulse,
  output logic      fallPulse
);

  logic prev_r;
  logic prev_nxt;
  logic rise_r;
  logic rise_nxt;
  logic fall_r;
  logic fall_nxt;

  always_comb begin
    prev_nxt = level;
    rise_nxt = level & ~prev_r;
    fall_nxt = ~level & prev_r;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign risePulse = rise_r;
  assign fallPulse = fall_r;

endmodule : stc_edge_detect

//--- verilog/stc_timer.sv
// 16-bit incrementing timer/counter with byte-wide register access.
// Assumes all pin inputs are synchronous to mclk; one clock domain.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.

// Functional notes
// - 16-bit up-counter, read and written as high and low bytes.
// - Writing either count byte changes the live count at once.
// - Internal instruction source advances once per instruction cycle.
// - External source advances the count on each selected edge.
// - On bit and gate-enable bit jointly govern counting.
// - Source select: 01 sys, 00 sys/4, 11 cap osc, 10 pin or crystal.
// - Prescaler divides source ticks by 1, 2, 4 or 8.
// - External sources count on their rising edge.
// - External mode needs a falling edge before the first counted rise.
module stc_timer
  import stc_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [ADDR_W-1:0]  regAddr,
  input  wire logic [DATA_W-1:0]  regWrData,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [DATA_W-1:0]  regRdData,
  input  wire logic               externalCountInput,
  input  wire logic               xtalOscIn,
  input  wire logic               capSenseOscIn,
  input  wire logic               gateIn,
  output logic      [COUNT_W-1:0] countValue
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [7:0]         ctrl_r;
  logic [7:0]         ctrl_nxt;
  logic [7:0]         gate_r;
  logic [7:0]         gate_nxt;
  logic [DATA_W-1:0]  rdData_r;
  logic [DATA_W-1:0]  rdData_nxt;
  logic [1:0]         div_r;
  logic [1:0]         div_nxt;
  logic               instrTick_r;
  logic               instrTick_nxt;
  logic [2:0]         presc_r;
  logic [2:0]         presc_nxt;
  stc_arm_e           arm_r;
  stc_arm_e           arm_nxt;

  logic               counterOn;
  logic               crystalOscEnable;
  logic [1:0]         countSourceSelect;
  logic [1:0]         prescSel;
  logic               gateEnable;
  logic               gatePolarity;
  logic               gateActive;
  logic               runEn;
  logic               extSel;
  logic               srcLevel;
  logic               extRise;
  logic               extFall;
  logic               srcTick;
  logic               cntWr;
  logic [2:0]         prescLast;
  logic               incr;

  // ------------------------------------------------------------------
  // Control decode
  // ------------------------------------------------------------------
  assign counterOn         = ctrl_r[CTRL_ON_BIT];
  assign crystalOscEnable  = ctrl_r[CTRL_OSCEN_BIT];
  assign countSourceSelect = ctrl_r[CTRL_SRC_LSB +: 2];
  assign prescSel          = ctrl_r[CTRL_PS_LSB +: 2];
  assign gateEnable        = gate_r[GATE_EN_BIT];
  assign gatePolarity      = gate_r[GATE_POL_BIT];
  assign gateActive        = (gateIn == gatePolarity);
  assign extSel            = stc_is_ext_src(countSourceSelect);
  assign cntWr             = regWr && stc_is_count_addr(regAddr);

  // Off / always on / gated
  assign runEn = counterOn && (!gateEnable || gateActive);

  // ------------------------------------------------------------------
  // Source selection and edge detection
  // ------------------------------------------------------------------
  always_comb begin
    srcLevel = 1'b0;
    if (countSourceSelect == SRC_CAP) begin
      srcLevel = capSenseOscIn;
    end else if (countSourceSelect == SRC_EXT) begin
      srcLevel = crystalOscEnable ? xtalOscIn : externalCountInput;
    end
  end

  stc_edge_detect u_stc_edge_detect (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .level     (srcLevel),
    .risePulse (extRise),
    .fallPulse (extFall)
  );

  // ------------------------------------------------------------------
  // Instruction clock divider
  // ------------------------------------------------------------------
  always_comb begin
    div_nxt       = div_r + 2'h1;
    instrTick_nxt = (div_r == INSTR_LAST);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_r       <= 2'h0;
      instrTick_r <= 1'b0;
    end else begin
      div_r       <= div_nxt;
      instrTick_r <= instrTick_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Edge arming for external counting
  // ------------------------------------------------------------------
  always_comb begin
    arm_nxt = arm_r;
    case (arm_r)
      ARM_WAIT_FALL: begin
        if (counterOn && !cntWr && extFall) begin
          arm_nxt = ARM_READY;
        end
      end
      ARM_READY: begin
        if (!counterOn || cntWr) begin
          arm_nxt = ARM_WAIT_FALL;
        end
      end
      default: begin
        arm_nxt = ARM_WAIT_FALL;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arm_r <= ARM_WAIT_FALL;
    end else begin
      arm_r <= arm_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Tick selection, prescaler and counter
  // ------------------------------------------------------------------
  always_comb begin
    case (countSourceSelect)
      SRC_SYS:   srcTick = 1'b1;
      SRC_INSTR: srcTick = instrTick_r;
      SRC_EXT:   srcTick = extRise && (arm_r == ARM_READY);
      SRC_CAP:   srcTick = extRise && (arm_r == ARM_READY);
      default:   srcTick = 1'b0;
    endcase
    case (prescSel)
      2'h0:    prescLast = 3'h0;
      2'h1:    prescLast = 3'h1;
      2'h2:    prescLast = 3'h3;
      default: prescLast = 3'h7;
    endcase
  end

  always_comb begin
    presc_nxt = presc_r;
    incr      = 1'b0;
    if (cntWr || !counterOn) begin
      presc_nxt = 3'h0;
    end else if (srcTick && runEn) begin
      if (presc_r >= prescLast) begin
        presc_nxt = 3'h0;
        incr      = 1'b1;
      end else begin
        presc_nxt = presc_r + 3'h1;
      end
    end
    count_nxt = count_r;
    if (regWr && regAddr == ADDR_CNT_LO) begin
      count_nxt = {count_r[15:8], regWrData};
    end else if (regWr && regAddr == ADDR_CNT_HI) begin
      count_nxt = {regWrData, count_r[7:0]};
    end else if (incr) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      presc_r <= 3'h0;
      count_r <= COUNT_RST;
    end else begin
      presc_r <= presc_nxt;
      count_r <= count_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_nxt   = ctrl_r;
    gate_nxt   = gate_r;
    rdData_nxt = 8'h00;
    if (regWr && regAddr == ADDR_CTRL) begin
      ctrl_nxt = regWrData;
    end
    if (regWr && regAddr == ADDR_GATE) begin
      gate_nxt = regWrData & 8'hC0;
    end
    if (regRd) begin
      case (regAddr)
        ADDR_CNT_LO: rdData_nxt = count_r[7:0];
        ADDR_CNT_HI: rdData_nxt = count_r[15:8];
        ADDR_CTRL:   rdData_nxt = ctrl_r;
        ADDR_GATE: begin
          rdData_nxt               = gate_r;
          rdData_nxt[GATE_LVL_BIT] = gateActive;
        end
        default:     rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r   <= CTRL_RST;
      gate_r   <= GATE_RST;
      rdData_r <= 8'h00;
    end else begin
      ctrl_r   <= ctrl_nxt;
      gate_r   <= gate_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData  = rdData_r;
  assign countValue = count_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  low_byte_write_a: assert property (
    regWr && regAddr == ADDR_CNT_LO |=> count_r[7:0] == $past(regWrData)
  ) else $error("low byte write did not reach the count");

  high_byte_write_a: assert property (
    regWr && regAddr == ADDR_CNT_HI |=>
      count_r == {$past(regWrData), $past(count_r[7:0])}
  ) else $error("high byte write did not reach the count");

  count_read_a: assert property (
    regRd && regAddr == ADDR_CNT_HI |=> regRdData == $past(count_r[15:8])
  ) else $error("high byte read returned wrong data");

  off_holds_a: assert property (
    !counterOn && !cntWr |=> count_r == $past(count_r)
  ) else $error("count moved while off");

  gate_holds_a: assert property (
    counterOn && gateEnable && !gateActive && !cntWr |=> $stable(count_r)
  ) else $error("count moved with gate closed");

  instr_rate_a: assert property (
    (countSourceSelect == SRC_INSTR && prescSel == 2'h0 && runEn && !cntWr)[*4]
      |=> count_r == $past(count_r, 4) + 16'h0001
  ) else $error("instruction clock rate wrong");

  sys_presc8_a: assert property (
    (countSourceSelect == SRC_SYS && prescSel == 2'h3 && runEn && !cntWr)[*8]
      |=> count_r == $past(count_r, 8) + 16'h0001
  ) else $error("prescaler divide by eight wrong");

  ext_rise_a: assert property (
    extSel && extRise && arm_r == ARM_READY && runEn && prescSel == 2'h0
      && !cntWr |=> count_r == $past(count_r) + 16'h0001
  ) else $error("external rising edge not counted");

  first_rise_a: assert property (
    extSel && extRise && arm_r == ARM_WAIT_FALL && !cntWr |=> $stable(count_r)
  ) else $error("rising edge counted before a falling edge");

  write_disarm_a: assert property (
    cntWr |=> arm_r == ARM_WAIT_FALL
  ) else $error("count write did not disarm edge counting");

  sys_rate_a: assert property (
    countSourceSelect == SRC_SYS && prescSel == 2'h0 && runEn && !cntWr
      |=> count_r == $past(count_r) + 16'h0001
  ) else $error("system clock source not counting each cycle");

  wrap_c: cover property (count_r == 16'hFFFF ##1 count_r == 16'h0000);
  ext_count_c: cover property (extSel && incr);
  gated_c: cover property (gateEnable && counterOn && incr);
  presc_c: cover property (prescSel == 2'h3 && incr);

endmodule : stc_timer

//--- sim/stc_ext_source.sv
// Model of the far-side count sources: pin, crystal and sensing oscillator.
// Assumes requests arrive by non-blocking assignment at a rising mclk edge.
module stc_ext_source (
  input  wire logic       mclk,
  input  wire logic [1:0] srcSel,
  input  wire logic       pulseReq,
  input  wire logic [3:0] pulseNum,
  output logic            busy,
  output logic            pinOut,
  output logic            xtalOut,
  output logic            capOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_r = 4'h0;
  logic [2:0] phase_r = 3'h0;
  logic       wave;
  // ------------------------------------------------------------------
  // Pulse train
  // ------------------------------------------------------------------
  // Three cycles high then three low; rises come first
  always @(posedge mclk) begin
    if (pulseReq) begin
      left_r  <= pulseNum;
      phase_r <= 3'h0;
    end else if (left_r != 4'h0) begin
      phase_r <= (phase_r == 3'h5) ? 3'h0 : phase_r + 3'h1;
      if (phase_r == 3'h5) left_r <= left_r - 4'h1;
    end
  end
  assign busy    = (left_r != 4'h0);
  assign wave    = busy && (phase_r < 3'h3);
  // Unselected sources rest low
  assign pinOut  = wave && (srcSel == 2'h0);
  assign xtalOut = wave && (srcSel == 2'h1);
  assign capOut  = wave && (srcSel == 2'h2);
endmodule : stc_ext_source

//--- sim/stc_timer_tb.sv
// Self-checking bench for the 16-bit timer/counter.
// Assumes the design package and the external source model are compiled first.
module stc_timer_tb;
  import stc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic               mclk = 1'b0;
  logic               rst_n = 1'b0;
  logic [ADDR_W-1:0]  regAddr = 4'h0;
  logic [DATA_W-1:0]  regWrData = 8'h00;
  logic               regWr = 1'b0;
  logic               regRd = 1'b0;
  logic [DATA_W-1:0]  regRdData;
  logic               gateIn = 1'b0;
  logic [COUNT_W-1:0] countValue;
  logic [1:0]         srcSel = 2'h0;
  logic               pulseReq = 1'b0;
  logic [3:0]         pulseNum = 4'h0;
  logic               busy, pinOut, xtalOut, capOut;
  int                 badCount = 0;
  int                 nCompared = 0;
  int                 cycles = 0;

  always #12.5 mclk = ~mclk;

  stc_timer u_stc_timer (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .externalCountInput(pinOut), .xtalOscIn(xtalOut), .capSenseOscIn(capOut),
    .gateIn(gateIn), .countValue(countValue)
  );
  stc_ext_source u_stc_ext_source (
    .mclk(mclk), .srcSel(srcSel), .pulseReq(pulseReq), .pulseNum(pulseNum),
    .busy(busy), .pinOut(pinOut), .xtalOut(xtalOut), .capOut(capOut)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr     <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  // Count change over n cycles after letting inputs settle
  task automatic delta(input int n, input logic [15:0] exp, input string nm);
    logic [15:0] c0;
    repeat (3) @(posedge mclk);
    #1 c0 = countValue;
    repeat (n) @(posedge mclk);
    #1 chk(nm, countValue - c0, exp);
  endtask : delta

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_map();
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), d);
      // Gate status bit reads open: pin low matches reset polarity
      chk("reset register", {8'h00, d}, (i == 3) ? 16'h0008 : 16'h0000);
    end
  endtask : t_reset_map

  task automatic t_byte_access();
    logic [7:0] d;
    wr(ADDR_CNT_LO, 8'h55);
    chk("count after low write", countValue, 16'h0055);
    wr(ADDR_CNT_HI, 8'hAA);
    chk("count after high write", countValue, 16'hAA55);
    rd(ADDR_CNT_LO, d);
    chk("low byte", {8'h00, d}, 16'h0055);
    rd(ADDR_CNT_HI, d);
    chk("high byte", {8'h00, d}, 16'h00AA);
  endtask : t_byte_access

  task automatic t_internal();
    wr(ADDR_CTRL, 8'h41);
    delta(20, 16'd20, "system clock count");
    wr(ADDR_CTRL, 8'h01);
    delta(40, 16'd10, "instruction clock count");
    wr(ADDR_CTRL, 8'h71);
    delta(64, 16'd8, "prescaled count");
  endtask : t_internal

  task automatic t_enable();
    logic [7:0] d;
    wr(ADDR_GATE, 8'h80);
    wr(ADDR_CTRL, 8'h40);
    delta(10, 16'd0, "off with gate enabled");
    wr(ADDR_CTRL, 8'h41);
    gateIn <= 1'b1;
    delta(10, 16'd0, "gate closed");
    gateIn <= 1'b0;
    delta(10, 16'd10, "gate open");
    wr(ADDR_GATE, 8'h00);
    gateIn <= 1'b1;
    delta(10, 16'd10, "always on");
    // High polarity; low six bits must not stick
    wr(ADDR_GATE, 8'hFF);
    rd(ADDR_GATE, d);
    chk("gate status", {8'h00, d}, 16'h00C8);
    delta(10, 16'd10, "gate open high");
    gateIn <= 1'b0;
    delta(10, 16'd0, "gate closed high");
    wr(ADDR_GATE, 8'h00);
    wr(ADDR_CTRL, 8'h00);
  endtask : t_enable

  // Pulse train from the source model, then settle
  task automatic pulses(input logic [3:0] n);
    int w;
    @(posedge mclk);
    pulseReq <= 1'b1;
    pulseNum <= n;
    @(posedge mclk);
    pulseReq <= 1'b0;
    w = 0;
    #1;
    while (busy !== 1'b0 && w < 100) begin
      @(posedge mclk);
      #1;
      w++;
    end
    chk("source finished", {15'h0000, busy}, 16'h0000);
    repeat (3) @(posedge mclk);
    #1;
  endtask : pulses

  task automatic t_external(input logic [1:0] sel, input logic [7:0] ctrl);
    wr(ADDR_CTRL, 8'h00);
    srcSel <= sel;
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, ctrl);
    pulses(4'h4);
    // First rise is not counted: no fall seen since enable
    chk("external count", countValue, 16'h0003);
    wr(ADDR_CNT_LO, 8'h00);
    pulses(4'h2);
    // A count write disarms until the next fall
    chk("count after rewrite", countValue, 16'h0001);
  endtask : t_external

  // ------------------------------------------------------------------
  // Main sequence and timeout
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset_map();
    t_byte_access();
    t_internal();
    t_enable();
    t_external(2'h0, 8'h81);
    t_external(2'h1, 8'h89);
    t_external(2'h2, 8'hC1);
    report_and_stop();
  end
endmodule : stc_timer_tb
